// ==== logic/flash_defines.svh ====
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
// opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS_WRITE 8'h01
`define OP_ENTER_WIDE 8'hb7
`define OP_EXIT_WIDE 8'he9
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_READ 8'h3b
// configuration and status field positions
`define CFG_WIDE_BIT 5
`define CFG_DC_LO_BIT 6
`define CFG_TB_BIT 3
`define SR_BP_LSB 2
`define CFG_RESET 8'h00
// address lengths in bits
`define ADDR_BITS_NARROW 6'd24
`define ADDR_BITS_WIDE 6'd32
// dummy clocks
`define FAST_DUMMY 6'd8
`define DUAL_DUMMY_00 6'd8
`define DUAL_DUMMY_01 6'd4
`define DUAL_DUMMY_10 6'd6
`define DUAL_DUMMY_11 6'd10
// smallest protected block
`define PROT_UNIT 32'h0001_0000
// busy time of a write cycle
`define CLK_NS 40
`define WRITE_CYCLE_NS 2000
`define WRITE_CYCLES ((`WRITE_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== logic/flash_pkg.sv ====
package flash_pkg;
  // link pins after synchronising
  typedef struct packed
  {
    logic cs_n;
    logic sclk;
    logic d0;
    logic d1;
  } link_in_t;
  // command sequencer phases
  typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_WSR, S_IGNORE} phase_t;
  // kind of array read in flight
  typedef enum logic [1:0] {K_READ, K_FAST, K_DUAL} read_kind_t;
endpackage : flash_pkg

// ==== logic/serial_flash_read_addr_mode.sv ====
`timescale 1ns/100ps
`include "flash_defines.svh"

// small fifo between the array and the output shifter
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D]; // storage
  logic [AW-1:0] wp_q; // write pointer
  logic [AW-1:0] rp_q; // read pointer
  logic [AW:0] cnt_q; // fill level
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers and level
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // data store, no reset needed
  always_ff @(posedge core_clk)
  begin
    if (push && !flush)
      mem[wp_q] <= in_data;
  end
endmodule : byte_fifo

// Overview of operation
// R1: refuse program or erase in protected area
// R2: protect bits change only after write enable
// R3: three address bytes after reset
// R4: enter command sets config bit 5, 32-bit addresses
// R5: only exit command or reset clears wide mode
// R6: exit command clears config bit 5
// R7: host sends enter and exit as opcode only
// R8: all commands keep working, address grows
// R9: address sampled rising, data changes falling
// R10: address increments per byte, wraps to zero
// R11: plain read: opcode, address, data, no dummy
// R12: fast read 0Bh: address, 8 dummy, data
// R13: fast and dual reads ignored while busy
// R14: dual read returns two bits per clock
// R15: dual dummy count from config bits 7:6
// R16: host uses wide mode or extended bit
// R17: wide mode address phase is four bytes
// R18: output lanes released outside data phase
module serial_flash_read_addr_mode
  import flash_pkg::*;
#(
  parameter int MEM_AW = 10,
  parameter logic [31:0] ARRAY_LAST = 32'h01ff_ffff,
  parameter int FIFO_DEPTH = 4,
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io_lane0_in,
  input wire logic io_lane1_in,
  output logic io_lane0_out,
  output logic io_lane0_oe,
  output logic io_lane1_out,
  output logic io_lane1_oe,
  input wire logic ext_addr_bit,
  input wire logic pgm_req,
  input wire logic [31:0] pgm_addr,
  input wire logic [7:0] pgm_data,
  output logic pgm_done,
  output logic pgm_refused,
  output logic wide_addr_flag,
  output logic write_enable_latch,
  output logic [3:0] block_protect_bits,
  output logic [7:0] config_reg,
  output logic busy
);
  logic [7:0] array_mem [2**MEM_AW]; // memory array
  logic [3:0] sync1_q; // first synchroniser stage
  link_in_t pin_q; // second synchroniser stage
  logic sclk_p_q; // previous sclk
  logic cs_p_q; // previous chip select
  phase_t st_q; // sequencer phase
  read_kind_t kind_q; // read kind
  logic [5:0] cnt_q; // bit count in phase
  logic [31:0] sh_q; // input shifter
  logic [31:0] rd_ptr_q; // prefetch address
  logic [7:0] obyte_q; // output shifter
  logic [2:0] left_q; // output steps left in byte
  logic [15:0] busy_cnt_q; // write cycle timer
  logic rise, fall, cs_rise, opc_done, addr_done;
  logic [7:0] opcode;
  logic [31:0] addr_full;
  logic [5:0] addr_len, dummy_len;
  logic fifo_in_ready, fifo_out_valid, pop, pgm_ok, wsr_ok;
  logic [7:0] fifo_out;

  // dummy clocks for dual reads from config bits 7:6
  function automatic logic [5:0] dual_dummy(input logic [1:0] dc);
    unique case (dc)
      2'b00: dual_dummy = `DUAL_DUMMY_00;
      2'b01: dual_dummy = `DUAL_DUMMY_01;
      2'b10: dual_dummy = `DUAL_DUMMY_10;
      2'b11: dual_dummy = `DUAL_DUMMY_11;
    endcase
  endfunction : dual_dummy

  // protected area: blocks grow by powers of two from top or bottom
  function automatic logic is_protected(input logic [31:0] a, input logic [3:0] bp, input logic tb);
    logic [31:0] size;
    logic [31:0] off;
    size = `PROT_UNIT << (bp - 4'h1);
    off = tb ? a : (ARRAY_LAST - a);
    is_protected = (bp != 4'h0) && (off < size);
  endfunction : is_protected

  // next array address with wrap
  function automatic logic [31:0] next_addr(input logic [31:0] a);
    next_addr = (a >= ARRAY_LAST) ? 32'h0000_0000 : a + 32'h0000_0001; // see R10
  endfunction : next_addr

  // two-flop synchronisers for the four link pins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 4'hf;
      pin_q <= '{cs_n: 1'b1, sclk: 1'b1, d0: 1'b0, d1: 1'b0};
      sclk_p_q <= 1'b1;
      cs_p_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {cs_n, sclk, io_lane0_in, io_lane1_in};
      pin_q <= sync1_q;
      sclk_p_q <= pin_q.sclk;
      cs_p_q <= pin_q.cs_n;
    end
  end

  // edge detection and decode
  assign rise = pin_q.sclk & ~sclk_p_q & ~pin_q.cs_n; // see R9
  assign fall = ~pin_q.sclk & sclk_p_q & ~pin_q.cs_n; // see R9
  assign cs_rise = pin_q.cs_n & ~cs_p_q;
  assign opcode = {sh_q[6:0], pin_q.d0};
  assign opc_done = rise && (st_q == S_CMD) && (cnt_q == 6'd7);
  assign addr_len = wide_addr_flag ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW; // see R3, R17
  assign addr_done = rise && (st_q == S_ADDR) && (cnt_q == addr_len - 6'd1);
  assign addr_full = wide_addr_flag ? {sh_q[30:0], pin_q.d0} // see R8
                                    : {7'h00, ext_addr_bit, sh_q[22:0], pin_q.d0};
  assign dummy_len = (kind_q == K_DUAL) ? dual_dummy(config_reg[`CFG_DC_LO_BIT +: 2]) // see R15
                                        : `FAST_DUMMY; // see R12
  assign pop = fall && (st_q == S_DATA) && (left_q == 3'd0) && fifo_out_valid;
  assign pgm_ok = pgm_req && !busy && write_enable_latch
                  && !is_protected(pgm_addr, block_protect_bits, config_reg[`CFG_TB_BIT]); // see R1
  assign wsr_ok = cs_rise && (st_q == S_WSR) && (cnt_q == 6'd8 || cnt_q == 6'd16)
                  && write_enable_latch && !busy; // see R2

  // command sequencer: opcode, address, dummy phases on rising edges
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_CMD;
      kind_q <= K_READ;
      cnt_q <= '0;
      sh_q <= '0;
    end
    else if (pin_q.cs_n)
    begin
      // deselect ends any command
      st_q <= S_CMD; // see R11
      cnt_q <= '0;
    end
    else if (rise)
    begin
      sh_q <= {sh_q[30:0], pin_q.d0};
      cnt_q <= (cnt_q == 6'd63) ? cnt_q : cnt_q + 6'd1;
      unique case (st_q)
        S_CMD:
        begin
          if (cnt_q == 6'd7)
          begin
            cnt_q <= '0;
            st_q <= S_IGNORE;
            // decode the opcode
            if (opcode == `OP_READ)
            begin
              kind_q <= K_READ;
              st_q <= S_ADDR;
            end
            else if (opcode == `OP_FAST_READ && !busy)
            begin
              kind_q <= K_FAST;
              st_q <= S_ADDR; // see R13
            end
            else if (opcode == `OP_DUAL_READ && !busy)
            begin
              kind_q <= K_DUAL;
              st_q <= S_ADDR; // see R13
            end
            else if (opcode == `OP_STATUS_WRITE)
              st_q <= S_WSR;
          end
        end
        S_ADDR:
        begin
          if (addr_done)
          begin
            cnt_q <= '0;
            st_q <= (kind_q == K_READ) ? S_DATA : S_DUMMY; // see R11
          end
        end
        S_DUMMY:
        begin
          if (cnt_q == dummy_len - 6'd1)
          begin
            cnt_q <= '0;
            st_q <= S_DATA; // see R12, R14
          end
        end
        S_DATA, S_WSR, S_IGNORE:
        begin
          // data-out and status bytes handled elsewhere
        end
      endcase
    end
  end

  // prefetch pointer: loaded from address, advanced per byte pushed
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_ptr_q <= '0;
    else if (addr_done)
      rd_ptr_q <= addr_full;
    else if ((st_q == S_DUMMY || st_q == S_DATA) && fifo_in_ready && !pin_q.cs_n)
      rd_ptr_q <= next_addr(rd_ptr_q); // see R10
  end

  // array write for accepted programs, index by low bits
  always_ff @(posedge core_clk)
  begin
    if (pgm_ok)
      array_mem[pgm_addr[MEM_AW-1:0]] <= pgm_data;
  end

  byte_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(pin_q.cs_n | addr_done),
    .in_valid((st_q == S_DUMMY || st_q == S_DATA) && !pin_q.cs_n),
    .in_data(array_mem[rd_ptr_q[MEM_AW-1:0]]),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(pop)
  );

  // output shifter: data changes on falling edges in data phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      obyte_q <= '0;
      left_q <= '0;
      io_lane0_out <= 1'b0;
      io_lane1_out <= 1'b0;
      io_lane0_oe <= 1'b0;
      io_lane1_oe <= 1'b0;
    end
    else if (st_q != S_DATA)
    begin
      // lanes released outside data-out
      left_q <= '0;
      io_lane0_oe <= 1'b0; // see R18
      io_lane1_oe <= 1'b0; // see R18
    end
    else if (fall && (left_q != 3'd0 || fifo_out_valid))
    begin
      io_lane1_oe <= 1'b1; // see R9
      io_lane0_oe <= (kind_q == K_DUAL);
      if (kind_q == K_DUAL)
      begin
        // two bits per clock, lane 1 carries the higher bit
        io_lane1_out <= (left_q == 3'd0) ? fifo_out[7] : obyte_q[7]; // see R14
        io_lane0_out <= (left_q == 3'd0) ? fifo_out[6] : obyte_q[6]; // see R14
        obyte_q <= ((left_q == 3'd0) ? fifo_out : obyte_q) << 2;
        left_q <= (left_q == 3'd0) ? 3'd3 : left_q - 3'd1;
      end
      else
      begin
        io_lane1_out <= (left_q == 3'd0) ? fifo_out[7] : obyte_q[7];
        obyte_q <= ((left_q == 3'd0) ? fifo_out : obyte_q) << 1;
        left_q <= (left_q == 3'd0) ? 3'd7 : left_q - 3'd1;
      end
    end
  end

  // write-enable latch, protect bits, configuration, busy timer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_enable_latch <= 1'b0;
      block_protect_bits <= 4'h0;
      config_reg <= `CFG_RESET; // see R3, R5
      busy_cnt_q <= '0;
      busy <= 1'b0;
      pgm_done <= 1'b0;
      pgm_refused <= 1'b0;
      wide_addr_flag <= 1'b0;
    end
    else
    begin
      pgm_done <= pgm_ok;
      pgm_refused <= pgm_req && !pgm_ok; // see R1
      busy <= (busy_cnt_q > 16'd1) || wsr_ok || pgm_ok;
      if (opc_done && opcode == `OP_ENTER_WIDE)
      begin
        config_reg[`CFG_WIDE_BIT] <= 1'b1; // see R4
        wide_addr_flag <= 1'b1; // see R4
      end
      if (opc_done && opcode == `OP_EXIT_WIDE)
      begin
        config_reg[`CFG_WIDE_BIT] <= 1'b0; // see R5, R6
        wide_addr_flag <= 1'b0; // see R6
      end
      if (wsr_ok)
      begin
        // status byte first, optional config byte second
        block_protect_bits <= (cnt_q == 6'd8) ? sh_q[`SR_BP_LSB +: 4] : sh_q[8 + `SR_BP_LSB +: 4]; // see R2
        if (cnt_q == 6'd16)
          config_reg <= {sh_q[7:6], config_reg[`CFG_WIDE_BIT], sh_q[4:0]}; // see R5
        write_enable_latch <= 1'b0;
        busy_cnt_q <= 16'(WRITE_CYCLES);
      end
      else if (pgm_ok)
      begin
        write_enable_latch <= 1'b0;
        busy_cnt_q <= 16'(WRITE_CYCLES);
      end
      else if (busy_cnt_q != 16'd0)
        busy_cnt_q <= busy_cnt_q - 16'd1;
      // write enable decoded in the cycle a write uses up the latch: set wins
      if (opc_done && opcode == `OP_WRITE_ENABLE)
        write_enable_latch <= 1'b1; // see R2
    end
  end
endmodule : serial_flash_read_addr_mode

// ==== bench/serial_flash_read_addr_mode_assertions.sv ====
`timescale 1ns/100ps
// port-level checks of the flash front end
module flash_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io_lane0_oe,
  input wire logic io_lane1_oe,
  input wire logic io_lane1_out,
  input wire logic pgm_req,
  input wire logic pgm_done,
  input wire logic pgm_refused,
  input wire logic wide_addr_flag,
  input wire logic write_enable_latch,
  input wire logic [7:0] config_reg,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // lanes released once select has been high a while
  property p_idle_hiz;
    cs_n [*6] |-> !io_lane0_oe && !io_lane1_oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("lane driven while deselected");
  // lane 0 only drives together with lane 1
  property p_dual_pair;
    io_lane0_oe |-> io_lane1_oe;
  endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("lane 0 driven alone");
  // mode flag mirrors its config bit
  property p_wide_cfg;
    wide_addr_flag == config_reg[5];
  endproperty
  a_wide_cfg: assert property (p_wide_cfg) else $error("wide flag and config bit differ");
  // mode only changes inside a selected frame
  property p_wide_cmd;
    $changed(wide_addr_flag) |-> !$past(cs_n, 3);
  endproperty
  a_wide_cmd: assert property (p_wide_cmd) else $error("wide mode changed outside a command");
  // every program request gets exactly one answer
  property p_prog_ans;
    pgm_req |=> pgm_done != pgm_refused;
  endproperty
  a_prog_ans: assert property (p_prog_ans) else $error("program answer missing");
  // accepted program starts a cycle and uses up the latch
  property p_prog_done;
    pgm_done |-> busy && (!write_enable_latch || !$past(cs_n, 3));
  endproperty
  a_prog_done: assert property (p_prog_done) else $error("accept without busy");
  // no latch, no program
  property p_latch_refuse;
    pgm_req && !write_enable_latch |=> pgm_refused;
  endproperty
  a_latch_refuse: assert property (p_latch_refuse) else $error("program without latch");
  // running cycle is not disturbed
  property p_busy_refuse;
    pgm_req && busy |=> pgm_refused;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("program while busy");
  // output bits move only after a falling clock
  property p_fall_edge;
    $changed(io_lane1_out) && io_lane1_oe && $past(io_lane1_oe) |-> !$past(sclk, 2);
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("data moved on high clock");
endmodule : flash_checker

// ==== bench/spi_host_model.sv ====
`timescale 1ns/100ps
// host controller: drives select, clock and lane 0
module spi_host_model (
  input wire logic core_clk,
  input wire logic lane0,
  input wire logic lane1,
  output logic cs_n,
  output logic sclk,
  output logic d0
);
  logic [7:0] rx_q[$]; // bytes captured in data phase
  logic [7:0] sh; // byte being collected
  // idle: deselected, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    d0 = 1'b0;
  end
  // one frame: n_tx bits msb first, n_dm dummies, n_rx bytes back
  task automatic frame(input logic [47:0] tx, input int n_tx, input int n_dm, input int n_rx, input bit du);
    int per;
    per = du ? 4 : 8;
    rx_q = {};
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n_tx + n_dm + n_rx * per; i++)
    begin
      @(posedge core_clk);
      sclk <= 1'b0;
      d0 <= (i < n_tx) ? tx[47 - i] : ~d0;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      // four core cycles low, four high: a 320 ns link clock
      repeat (3) @(posedge core_clk);
      // sample just before the next fall
      if (i >= n_tx + n_dm)
      begin
        sh = du ? {sh[5:0], lane1, lane0} : {sh[6:0], lane1};
        if ((i - n_tx - n_dm) % per == per - 1)
          rx_q.push_back(sh);
      end
    end
    @(posedge core_clk);
    sclk <= 1'b0;
    repeat (2) @(posedge core_clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : frame
endmodule : spi_host_model

// ==== bench/serial_flash_read_addr_mode_tb.sv ====
`timescale 1ns/100ps
`include "flash_defines.svh"
module serial_flash_read_addr_mode_tb;
  localparam logic [31:0] LAST = 32'h01ff_ffff; // top of array
  logic core_clk = 1'b0, rst_n = 1'b0, tog = 1'b0, h_d0, cs_n, sclk;
  logic io_lane0_in, io_lane1_in, io_lane0_out, io_lane0_oe, io_lane1_out, io_lane1_oe;
  logic ext_addr_bit = 1'b0, pgm_req = 1'b0, pgm_done, pgm_refused, busy;
  logic [31:0] pgm_addr = 32'h0;
  logic [7:0] pgm_data = 8'h00, config_reg;
  logic wide_addr_flag, write_enable_latch;
  logic [3:0] block_protect_bits;
  logic [7:0] mem [1024]; // expected array contents
  int error_cnt = 0, checks_done = 0, oe_cnt = 0;
  int dtab[4] = '{`DUAL_DUMMY_00, `DUAL_DUMMY_01, `DUAL_DUMMY_10, `DUAL_DUMMY_11};
  // clock, a changing pattern on the free lane, lane resolution
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) tog <= ~tog;
  always @(posedge core_clk) if (io_lane1_oe === 1'b1) oe_cnt++;
  assign io_lane0_in = io_lane0_oe ? io_lane0_out : h_d0;
  assign io_lane1_in = io_lane1_oe ? io_lane1_out : tog;
  serial_flash_read_addr_mode #(.ARRAY_LAST(LAST), .WRITE_CYCLES(150)) dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .io_lane0_in(io_lane0_in),
    .io_lane1_in(io_lane1_in),
    .io_lane0_out(io_lane0_out),
    .io_lane0_oe(io_lane0_oe),
    .io_lane1_out(io_lane1_out),
    .io_lane1_oe(io_lane1_oe),
    .ext_addr_bit(ext_addr_bit),
    .pgm_req(pgm_req),
    .pgm_addr(pgm_addr),
    .pgm_data(pgm_data),
    .pgm_done(pgm_done),
    .pgm_refused(pgm_refused),
    .wide_addr_flag(wide_addr_flag),
    .write_enable_latch(write_enable_latch),
    .block_protect_bits(block_protect_bits),
    .config_reg(config_reg),
    .busy(busy)
  );
  // next expected array address, wrapping after the top
  function automatic logic [31:0] nxt(input logic [31:0] x);
    nxt = (x == LAST) ? 32'h0 : x + 32'h1;
  endfunction : nxt
  spi_host_model host_u (.core_clk(core_clk), .lane0(io_lane0_in), .lane1(io_lane1_in),
    .cs_n(cs_n), .sclk(sclk), .d0(h_d0));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // bounded wait for the write cycle to end
  task automatic wait_idle;
    for (int k = 0; k < 300 && busy !== 1'b0; k++)
      @(posedge core_clk);
    if (busy !== 1'b0)
    begin
      error_cnt++;
      $display("wrong value at %0t: write cycle never ended", $time);
      report_and_stop;
    end
  endtask : wait_idle
  // opcode-only frame
  task automatic op1(input logic [7:0] op);
    host_u.frame({op, 40'h0}, 8, 0, 0, 0);
  endtask : op1
  // status write of n bits, optionally after write enable
  task automatic wsr(input logic [15:0] v, input int n, input bit en);
    if (en)
      op1(`OP_WRITE_ENABLE);
    host_u.frame({`OP_STATUS_WRITE, v, 24'h0}, 8 + n, 0, 0, 0);
    wait_idle;
  endtask : wsr
  // program a random byte, expect accept or refuse, then poke again (while busy if accepted)
  task automatic prog(input logic [31:0] a, input bit en, input bit e, input bit br);
    logic [7:0] d;
    int n;
    d = 8'($urandom);
    if (en)
      op1(`OP_WRITE_ENABLE);
    @(posedge core_clk);
    pgm_req <= 1'b1;
    pgm_addr <= a;
    pgm_data <= d;
    @(posedge core_clk);
    pgm_req <= 1'b0;
    #1 chk({pgm_done, pgm_refused}, {e, !e});
    if (e)
      mem[a[9:0]] = d;
    @(posedge core_clk);
    pgm_req <= 1'b1;
    @(posedge core_clk);
    pgm_req <= 1'b0;
    #1 chk(pgm_refused, 1'b1);
    n = oe_cnt;
    if (br)
      host_u.frame({`OP_FAST_READ, 40'h0}, 32, 8, 1, 0);
    chk(oe_cnt - n, 0);
    wait_idle;
  endtask : prog
  // read n bytes, e is the effective start address
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [31:0] e, input int n,
    input int nd, input bit du, input bit w);
    host_u.frame(w ? {op, a, 8'h00} : {op, a[23:0], 16'h0000}, w ? 40 : 32, nd, n, du);
    for (int i = 0; i < n; i++)
    begin
      chk(host_u.rx_q[i], mem[e[9:0]]);
      e = nxt(e);
    end
  endtask : rd
  // main sequence
  initial
  begin
    logic [31:0] a;
    void'($urandom(53174));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk({wide_addr_flag, write_enable_latch, block_protect_bits, config_reg, busy, io_lane1_oe}, 0);
    prog(32'h5, 0, 0, 0);
    for (int i = 0; i < 8; i++)
      prog(i, 1, 1, 0);
    prog(LAST, 1, 1, 0);
    $display("test programming done");
    a = $urandom_range(0, 4);
    rd(`OP_READ, a, a, 3, 0, 0, 0);
    rd(`OP_FAST_READ, a, a, 3, `FAST_DUMMY, 0, 0);
    $display("test narrow reads done");
    for (int dc = 0; dc < 4; dc++)
    begin
      wsr({8'h00, 2'(dc), 6'h20}, 16, 1);
      chk({config_reg[7:6], wide_addr_flag}, {2'(dc), 1'b0});
      rd(`OP_DUAL_READ, 32'h0, 32'h0, 2, dtab[dc], 1, 0);
    end
    $display("test dual reads done");
    op1(`OP_ENTER_WIDE);
    chk({wide_addr_flag, config_reg[5]}, 2'b11);
    rd(`OP_READ, LAST, LAST, 3, 0, 0, 1);
    rd(`OP_DUAL_READ, 32'h0, 32'h0, 2, dtab[3], 1, 1);
    wsr(16'h0000, 16, 1);
    chk(wide_addr_flag, 1'b1);
    op1(`OP_EXIT_WIDE);
    chk({wide_addr_flag, config_reg[5]}, 2'b00);
    ext_addr_bit <= 1'b1;
    rd(`OP_FAST_READ, 32'h00ff_ffff, LAST, 2, `FAST_DUMMY, 0, 0);
    ext_addr_bit <= 1'b0;
    $display("test wide mode done");
    op1(`OP_ENTER_WIDE);
    op1(`OP_WRITE_ENABLE);
    chk({wide_addr_flag, write_enable_latch}, 2'b11);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk({wide_addr_flag, write_enable_latch, config_reg}, 0);
    $display("test mid-run reset done");
    wsr(16'h0400, 8, 0);
    chk(block_protect_bits, 4'h0);
    wsr(16'h0400, 8, 1);
    chk(block_protect_bits, 4'h1);
    prog(32'h01ff_0010, 1, 0, 0);
    prog(32'h20, 1, 1, 1);
    rd(`OP_READ, 32'h20, 32'h20, 1, 0, 0, 0);
    wsr(16'h0408, 16, 1);
    chk({block_protect_bits, config_reg[3]}, 5'h03);
    prog(32'h30, 1, 0, 0);
    prog(32'h01ff_0010, 1, 1, 0);
    rd(`OP_READ, 32'h01ff_0010, 32'h01ff_0010, 1, 0, 0, 0);
    $display("test protection done");
    report_and_stop;
  end
endmodule : serial_flash_read_addr_mode_tb
bind serial_flash_read_addr_mode flash_checker chk_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cs_n(cs_n),
  .sclk(sclk),
  .io_lane0_oe(io_lane0_oe),
  .io_lane1_oe(io_lane1_oe),
  .io_lane1_out(io_lane1_out),
  .pgm_req(pgm_req),
  .pgm_done(pgm_done),
  .pgm_refused(pgm_refused),
  .wide_addr_flag(wide_addr_flag),
  .write_enable_latch(write_enable_latch),
  .config_reg(config_reg),
  .busy(busy)
);
